// ==== core/frame_fifo_pkg.sv ====
package frame_fifo_pkg;

  // Transmit storage: 8 KB held as 32-bit words.
  localparam int TX_FIFO_BYTES  = 8192;
  localparam int BYTES_PER_WORD = 4;
  localparam int TX_DEPTH       = TX_FIFO_BYTES / BYTES_PER_WORD;
  localparam int TX_IDX_W       = 11;
  localparam int TX_PTR_W       = 12;
  localparam int RX_PTR_W       = 10;
  localparam int APB_ADDR_W     = 12;

  localparam logic [TX_PTR_W-1:0] TX_FULL_LEVEL = 12'h800;
  localparam logic [TX_PTR_W-1:0] TX_PTR_STEP   = 12'h001;
  localparam logic [11:0]         BYTE_STEP     = 12'h004;
  localparam logic [11:0]         WORD_ROUND    = 12'h003;

  // Register byte addresses.
  localparam logic [APB_ADDR_W-1:0] OFS_MAC_CONTROL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFS_RX_CONFIG   = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFS_STATUS      = 12'h008;

  // Register bit positions.
  localparam int RECEIVER_ENABLE_POS = 0;
  localparam int RX_FLUSH_POS        = 0;
  localparam int STAT_TX_ERROR_POS   = 0;
  localparam int STAT_RX_STOPPED_POS = 1;
  localparam int STAT_CRC_ERROR_POS  = 2;

  localparam logic RECEIVER_ENABLE_RESET = 1'b0;

  // Transmit command word A fields.
  localparam int A_SIZE_LSB   = 0;
  localparam int A_SIZE_W     = 11;
  localparam int A_LAST_POS   = 12;
  localparam int A_FIRST_POS  = 13;
  localparam int A_OFFSET_LSB = 16;
  localparam int A_OFFSET_W   = 2;

  // Transmit command word B fields.
  localparam int B_FLEN_LSB   = 0;
  localparam int B_FLEN_W     = 11;
  localparam logic [31:0] B_CHECKSUM_MASK = 32'h0000_4000;

  typedef enum logic [2:0]
  {
    PARSE_CMD_A = 3'b001,
    PARSE_CMD_B = 3'b010,
    PARSE_DATA  = 3'b100
  } parse_state_t;

endpackage

// ==== core/tx_word_store.sv ====
`timescale 1ns/10ps
`default_nettype none

// Flop storage for the transmit words; no reset so it maps to plain flops.
module tx_word_store
(
  input  wire logic                                   clk_sys,
  input  wire logic                                   wr_en,
  input  wire logic [frame_fifo_pkg::TX_IDX_W-1:0]    wr_idx,
  input  wire logic [31:0]                            wr_data,
  input  wire logic [frame_fifo_pkg::TX_IDX_W-1:0]    rd_idx,
  output logic      [31:0]                            rd_data
);

  logic [31:0] mem_reg [frame_fifo_pkg::TX_DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem_reg[rd_idx];

endmodule

`default_nettype wire

// ==== core/frame_fifo_controller.sv ====
// Summary of operation
// - Set the CRC error flag when the frame check sequence fails.
// - Also set the CRC error flag when rx_er appeared during the frame.
// - CRC flag is marked invalid for runt, late collision, watchdog frames.
// - A receive flush returns both receive pointers to their reset value.
// - The flush bit clears itself when the flush is done.
// - One pulse on receiver_stopped_pulse when the receiver truly halts.
// - An 8 KB transmit store holds bulk-out packets from USB.
// - Frames are pulled from the store and sent to the transmit layer.
// - Writes use a store pointer and a packet head pointer for rewind.
// - The write side stores bytes unchanged; parsing is on the read side.
// - Each buffer starts with two command words before its data.
// - Command B words differing outside checksum bit 14 set the transmitter error flag.
// - Declared frame length not equal to received bytes is an error.
// - First and last segment flags in command A mark frame bounds.
// - Buffer sizes are summed per frame and checked against length.
// - Data start offset selects the first valid byte lane.
// - Frame length sits in bits 10:0 of command B.
`timescale 1ns/10ps
`default_nettype none

module frame_fifo_controller
(
  input  wire logic                                 clk_sys,
  input  wire logic                                 resetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [frame_fifo_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                          pwdata,
  output logic                                      pready,
  output logic      [31:0]                          prdata,
  output logic                                      pslverr,
  input  wire logic                                 rx_busy,
  input  wire logic                                 rx_er,
  input  wire logic                                 rx_frame_done,
  input  wire logic                                 rx_fcs_ok,
  input  wire logic                                 rx_runt,
  input  wire logic                                 rx_late_collision,
  input  wire logic                                 rx_watchdog_expired,
  input  wire logic                                 rx_push,
  input  wire logic                                 rx_pop,
  output logic                                      rx_enable,
  output logic                                      receiver_stopped_pulse,
  output logic                                      rx_crc_error,
  output logic                                      rx_crc_valid,
  output logic                                      rx_status_strobe,
  output logic      [frame_fifo_pkg::RX_PTR_W-1:0]  rx_wr_index,
  output logic      [frame_fifo_pkg::RX_PTR_W-1:0]  rx_rd_index,
  input  wire logic                                 usb_wr_valid,
  input  wire logic [31:0]                          usb_wr_data,
  input  wire logic                                 usb_pkt_end,
  input  wire logic                                 usb_pkt_rewind,
  output logic                                      usb_wr_ready,
  output logic                                      xmit_valid,
  output logic      [31:0]                          xmit_data,
  output logic      [3:0]                           xmit_be,
  output logic                                      xmit_last,
  input  wire logic                                 xmit_ready,
  output logic                                      transmitter_error_flag
);

  localparam int PW = frame_fifo_pkg::TX_PTR_W;
  localparam int RW = frame_fifo_pkg::RX_PTR_W;

  // A lane is valid when its byte position lies in [offset, end).
  function automatic logic [3:0] byte_enables(input logic [11:0] base,
                                              input logic [11:0] first,
                                              input logic [11:0] stop);
    logic [11:0] p;
    byte_enables = 4'h0;
    for (int i = 0; i < frame_fifo_pkg::BYTES_PER_WORD; i++)
    begin
      p = base + 12'(i);
      byte_enables[i] = (p >= first) && (p < stop);
    end
  endfunction

  // Control and status registers.
  logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        enable_bit_reg, enable_bit_next;
  logic        flush_reg, flush_next;
  logic        txe_reg, txe_next;
  // Receive path.
  logic          running_reg, running_next, stop_pulse_reg, stop_pulse_next;
  logic          er_seen_reg, er_seen_next, crc_err_reg, crc_err_next;
  logic          crc_valid_reg, crc_valid_next, strobe_reg, strobe_next;
  logic [RW-1:0] rxw_reg, rxw_next, rxr_reg, rxr_next;
  // Transmit write side.
  logic [PW-1:0] store_reg, store_next, head_reg, head_next;
  logic          wready_reg, wready_next, wr_en;
  // Transmit read side.
  frame_fifo_pkg::parse_state_t state_reg, state_next;
  logic [PW-1:0] rd_reg, rd_next;
  logic [31:0]   rd_word, cmd_a_reg, cmd_a_next, bref_reg, bref_next;
  logic          in_frame_reg, in_frame_next, lastseg_reg, lastseg_next;
  logic [11:0]   acc_reg, acc_next, off_reg, off_next, end_reg, end_next;
  logic [11:0]   base_reg, base_next, acc_sum, round_up;
  logic [9:0]    dw_reg, dw_next;
  logic          xv_reg, xv_next, xl_reg, xl_next;
  logic [31:0]   xd_reg, xd_next;
  logic [3:0]    xb_reg, xb_next;
  logic          avail, slot, b_fail, len_fail, access, commit;

  tx_word_store u_store
  (
    .clk_sys (clk_sys),
    .wr_en   (wr_en),
    .wr_idx  (store_reg[frame_fifo_pkg::TX_IDX_W-1:0]),
    .wr_data (usb_wr_data),
    .rd_idx  (rd_reg[frame_fifo_pkg::TX_IDX_W-1:0]),
    .rd_data (rd_word)
  );

  // The slave inserts one wait state so read data can come from a flop.
  // A write lands only at the edge where the master sees pready high.
  always_comb
  begin
    access          = psel && penable && !pready_reg;
    commit          = psel && penable && pready_reg && pwrite;
    pready_next     = access;
    pslverr_next    = 1'b0;
    prdata_next     = 32'h0000_0000;
    enable_bit_next = enable_bit_reg;
    flush_next      = 1'b0;
    txe_next        = txe_reg;
    if (access || commit)
    begin
      case (paddr)
        frame_fifo_pkg::OFS_MAC_CONTROL:
        begin
          prdata_next = 32'(enable_bit_reg);
          if (commit)
          begin
            enable_bit_next = pwdata[frame_fifo_pkg::RECEIVER_ENABLE_POS];
          end
        end
        frame_fifo_pkg::OFS_RX_CONFIG:
        begin
          prdata_next = 32'(flush_reg);
          if (commit && pwdata[frame_fifo_pkg::RX_FLUSH_POS])
          begin
            flush_next = 1'b1;
          end
        end
        frame_fifo_pkg::OFS_STATUS:
        begin
          prdata_next[frame_fifo_pkg::STAT_TX_ERROR_POS]   = txe_reg;
          prdata_next[frame_fifo_pkg::STAT_RX_STOPPED_POS] = !running_reg;
          prdata_next[frame_fifo_pkg::STAT_CRC_ERROR_POS]  = crc_err_reg;
          if (commit && pwdata[frame_fifo_pkg::STAT_TX_ERROR_POS])
          begin
            txe_next = 1'b0;
          end
        end
        default: pslverr_next = access;
      endcase
    end
    // Read data is shown only in the cycle in which pready stands.
    if (!access)
    begin
      prdata_next = 32'h0000_0000;
    end
    // A new error wins over a clear in the same cycle.
    if (b_fail || len_fail)
    begin
      txe_next = 1'b1;
    end
  end

  always_comb
  begin
    running_next    = running_reg;
    stop_pulse_next = 1'b0;
    if (enable_bit_reg && !running_reg)
    begin
      running_next = 1'b1;
    end
    else if (!enable_bit_reg && running_reg && !rx_busy)
    begin
      running_next    = 1'b0;
      stop_pulse_next = 1'b1;
    end
    er_seen_next   = er_seen_reg || (rx_er && rx_busy);
    crc_err_next   = crc_err_reg;
    crc_valid_next = crc_valid_reg;
    strobe_next    = rx_frame_done;
    if (rx_frame_done)
    begin
      er_seen_next   = 1'b0;
      crc_err_next   = !rx_fcs_ok || er_seen_reg || rx_er;
      crc_valid_next = !(rx_runt || rx_late_collision
                         || rx_watchdog_expired);
    end
    rxw_next = rxw_reg + RW'(rx_push);
    rxr_next = rxr_reg + RW'(rx_pop);
    if (flush_reg)
    begin
      rxw_next = '0;
      rxr_next = '0;
    end
  end

  // Rewind takes priority and drops any word offered in the same cycle.
  always_comb
  begin
    wr_en      = usb_wr_valid && wready_reg && !usb_pkt_rewind;
    store_next = store_reg + (wr_en ? frame_fifo_pkg::TX_PTR_STEP : '0);
    head_next  = head_reg;
    if (usb_pkt_rewind)
    begin
      store_next = head_reg;
    end
    else if (usb_pkt_end)
    begin
      head_next = store_next;
    end
    wready_next = (store_next - rd_next) != frame_fifo_pkg::TX_FULL_LEVEL;
  end

  // Only committed packets, up to the head pointer, are parsed.
  always_comb
  begin
    avail         = rd_reg != head_reg;
    slot          = !xv_reg || xmit_ready;
    state_next    = state_reg;
    rd_next       = rd_reg;
    cmd_a_next    = cmd_a_reg;
    bref_next     = bref_reg;
    in_frame_next = in_frame_reg;
    lastseg_next  = lastseg_reg;
    acc_next      = acc_reg;
    off_next      = off_reg;
    end_next      = end_reg;
    base_next     = base_reg;
    dw_next       = dw_reg;
    xv_next       = xv_reg && !xmit_ready;
    xd_next       = xd_reg;
    xb_next       = xb_reg;
    xl_next       = xl_reg;
    b_fail        = 1'b0;
    len_fail      = 1'b0;
    acc_sum       = '0;
    round_up      = '0;
    case (state_reg)
      frame_fifo_pkg::PARSE_CMD_A:
      begin
        if (avail)
        begin
          cmd_a_next = rd_word;
          rd_next    = rd_reg + frame_fifo_pkg::TX_PTR_STEP;
          state_next = frame_fifo_pkg::PARSE_CMD_B;
        end
      end
      frame_fifo_pkg::PARSE_CMD_B:
      begin
        if (avail)
        begin
          rd_next = rd_reg + frame_fifo_pkg::TX_PTR_STEP;
          if (cmd_a_reg[frame_fifo_pkg::A_FIRST_POS])
          begin
            bref_next = rd_word;
            acc_sum   = 12'(cmd_a_reg[frame_fifo_pkg::A_SIZE_LSB +:
                                      frame_fifo_pkg::A_SIZE_W]);
          end
          else
          begin
            b_fail  = in_frame_reg && (((rd_word ^ bref_reg)
                      & ~frame_fifo_pkg::B_CHECKSUM_MASK) != '0);
            acc_sum = acc_reg + 12'(cmd_a_reg[frame_fifo_pkg::A_SIZE_LSB +:
                                              frame_fifo_pkg::A_SIZE_W]);
          end
          acc_next      = acc_sum;
          lastseg_next  = cmd_a_reg[frame_fifo_pkg::A_LAST_POS];
          in_frame_next = !cmd_a_reg[frame_fifo_pkg::A_LAST_POS];
          if (cmd_a_reg[frame_fifo_pkg::A_LAST_POS])
          begin
            len_fail = acc_sum != 12'(rd_word[
                    frame_fifo_pkg::B_FLEN_LSB +: frame_fifo_pkg::B_FLEN_W]);
          end
          off_next  = 12'(cmd_a_reg[frame_fifo_pkg::A_OFFSET_LSB +:
                                    frame_fifo_pkg::A_OFFSET_W]);
          end_next  = off_next + 12'(cmd_a_reg[frame_fifo_pkg::A_SIZE_LSB +:
                                               frame_fifo_pkg::A_SIZE_W]);
          base_next = '0;
          round_up  = end_next + frame_fifo_pkg::WORD_ROUND;
          dw_next   = round_up[11:2];
          state_next = (dw_next == '0) ? frame_fifo_pkg::PARSE_CMD_A
                                       : frame_fifo_pkg::PARSE_DATA;
        end
      end
      frame_fifo_pkg::PARSE_DATA:
      begin
        if (avail && slot)
        begin
          xv_next   = 1'b1;
          xd_next   = rd_word;
          xb_next   = byte_enables(base_reg, off_reg, end_reg);
          xl_next   = lastseg_reg && (dw_reg == 10'h001);
          rd_next   = rd_reg + frame_fifo_pkg::TX_PTR_STEP;
          base_next = base_reg + frame_fifo_pkg::BYTE_STEP;
          dw_next   = dw_reg - 10'h001;
          if (dw_reg == 10'h001)
          begin
            state_next = frame_fifo_pkg::PARSE_CMD_A;
          end
        end
      end
      default: state_next = frame_fifo_pkg::PARSE_CMD_A;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      enable_bit_reg <= frame_fifo_pkg::RECEIVER_ENABLE_RESET;
      flush_reg <= 1'b0;
      txe_reg <= 1'b0;
      running_reg <= 1'b0;
      stop_pulse_reg <= 1'b0;
      er_seen_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      crc_valid_reg <= 1'b0;
      strobe_reg <= 1'b0;
      rxw_reg <= '0;
      rxr_reg <= '0;
      store_reg <= '0;
      head_reg <= '0;
      wready_reg <= 1'b0;
      state_reg <= frame_fifo_pkg::PARSE_CMD_A;
      rd_reg <= '0;
      cmd_a_reg <= 32'h0000_0000;
      bref_reg <= 32'h0000_0000;
      in_frame_reg <= 1'b0;
      lastseg_reg <= 1'b0;
      acc_reg <= '0;
      off_reg <= '0;
      end_reg <= '0;
      base_reg <= '0;
      dw_reg <= '0;
      xv_reg <= 1'b0;
      xd_reg <= 32'h0000_0000;
      xb_reg <= 4'h0;
      xl_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      enable_bit_reg <= enable_bit_next;
      flush_reg <= flush_next;
      txe_reg <= txe_next;
      running_reg <= running_next;
      stop_pulse_reg <= stop_pulse_next;
      er_seen_reg <= er_seen_next;
      crc_err_reg <= crc_err_next;
      crc_valid_reg <= crc_valid_next;
      strobe_reg <= strobe_next;
      rxw_reg <= rxw_next;
      rxr_reg <= rxr_next;
      store_reg <= store_next;
      head_reg <= head_next;
      wready_reg <= wready_next;
      state_reg <= state_next;
      rd_reg <= rd_next;
      cmd_a_reg <= cmd_a_next;
      bref_reg <= bref_next;
      in_frame_reg <= in_frame_next;
      lastseg_reg <= lastseg_next;
      acc_reg <= acc_next;
      off_reg <= off_next;
      end_reg <= end_next;
      base_reg <= base_next;
      dw_reg <= dw_next;
      xv_reg <= xv_next;
      xd_reg <= xd_next;
      xb_reg <= xb_next;
      xl_reg <= xl_next;
    end
  end

  assign pready                 = pready_reg;
  assign pslverr                = pslverr_reg;
  assign prdata                 = prdata_reg;
  assign rx_enable              = running_reg;
  assign receiver_stopped_pulse = stop_pulse_reg;
  assign rx_crc_error           = crc_err_reg;
  assign rx_crc_valid           = crc_valid_reg;
  assign rx_status_strobe       = strobe_reg;
  assign rx_wr_index            = rxw_reg;
  assign rx_rd_index            = rxr_reg;
  assign usb_wr_ready           = wready_reg;
  assign xmit_valid             = xv_reg;
  assign xmit_data              = xd_reg;
  assign xmit_be                = xb_reg;
  assign xmit_last              = xl_reg;
  assign transmitter_error_flag = txe_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_crc_check_fail: assert property (
    rx_frame_done && !rx_fcs_ok |=> rx_crc_error)
    else $error("crc flag not set");
  a_crc_rx_er: assert property (
    rx_busy && rx_er && !rx_frame_done ##1 rx_frame_done |=> rx_crc_error)
    else $error("rx_er lost");
  a_crc_not_valid: assert property (
    rx_frame_done && rx_runt |=> !rx_crc_valid && rx_status_strobe)
    else $error("runt crc marked valid");
  a_flush_pointers: assert property (
    flush_reg |=> rx_wr_index == '0 && rx_rd_index == '0)
    else $error("flush left pointers");
  a_flush_self_clear: assert property (
    $rose(flush_reg) |=> !flush_reg)
    else $error("flush bit stuck");
  a_stop_single_pulse: assert property (
    receiver_stopped_pulse |-> !rx_enable && $past(rx_enable)
    ##1 !receiver_stopped_pulse)
    else $error("bad stop pulse");
  a_rewind_reload: assert property (
    usb_pkt_rewind |=> store_reg == $past(head_reg)
    && head_reg == $past(head_reg))
    else $error("rewind failed");
  a_head_commit: assert property (
    usb_pkt_end && !usb_pkt_rewind |=> head_reg == store_reg)
    else $error("head not advanced");
  a_cmd_b_mismatch: assert property (
    b_fail |=> transmitter_error_flag)
    else $error("b mismatch missed");
  a_length_mismatch: assert property (
    len_fail |=> transmitter_error_flag [*2])
    else $error("length error missed");
  a_xmit_hold: assert property (
    xmit_valid && !xmit_ready |=> xmit_valid && $stable(xmit_data)
    && $stable(xmit_be))
    else $error("xmit word dropped");

  c_receiver_stop: cover property (receiver_stopped_pulse);
  c_flush_done: cover property ($fell(flush_reg));
  c_frame_last: cover property (xmit_valid && xmit_ready && xmit_last);
  c_tx_error: cover property ($rose(transmitter_error_flag));

endmodule

`default_nettype wire

// ==== bench/xmit_sink_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Transmit layer sink; it stalls one cycle in three so held beats occur.
module xmit_sink_model
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  output logic      xmit_ready
);
  logic [1:0] phase_reg;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      phase_reg <= 2'h0;
    else
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
  end
  assign xmit_ready = (phase_reg != 2'h0);
endmodule

`default_nettype wire

// ==== bench/frame_fifo_controller_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module frame_fifo_controller_test;
  logic clk_sys = 1'b0, resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata, w_data = 32'h0;
  logic pready, pslverr, rerr;
  logic rx_busy = 1'b0, rx_er = 1'b0, done = 1'b0, fcs = 1'b0, runt = 1'b0;
  logic late = 1'b0, wd = 1'b0, push = 1'b0, pop = 1'b0;
  logic rx_enable, stop_p, crc_err, crc_ok, strobe;
  logic [9:0] wr_i, rd_i;
  logic w_valid = 1'b0, w_end = 1'b0, rewind = 1'b0, w_ready;
  logic x_valid, x_last, x_ready, tx_err;
  logic [31:0] x_data;
  logic [3:0] x_be;
  logic [36:0] notes[$];
  int miscompares = 0, n_compared = 0, stops = 0, i, k;
  integer seed = 32'h12a3;
  logic [4:0] crc_tab[6] = '{5'h00, 5'h18, 5'h10, 5'h04, 5'h02, 5'h01};

  always #5 clk_sys = ~clk_sys;

  frame_fifo_controller i_frame_fifo_controller
  (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .rx_busy(rx_busy), .rx_er(rx_er),
   .rx_frame_done(done), .rx_fcs_ok(fcs), .rx_runt(runt),
   .rx_late_collision(late), .rx_watchdog_expired(wd), .rx_push(push),
   .rx_pop(pop), .rx_enable(rx_enable), .receiver_stopped_pulse(stop_p),
   .rx_crc_error(crc_err), .rx_crc_valid(crc_ok), .rx_status_strobe(strobe),
   .rx_wr_index(wr_i), .rx_rd_index(rd_i), .usb_wr_valid(w_valid),
   .usb_wr_data(w_data), .usb_pkt_end(w_end), .usb_pkt_rewind(rewind),
   .usb_wr_ready(w_ready), .xmit_valid(x_valid), .xmit_data(x_data),
   .xmit_be(x_be), .xmit_last(x_last), .xmit_ready(x_ready),
   .transmitter_error_flag(tx_err));

  xmit_sink_model i_xmit_sink_model
  (.clk_sys(clk_sys), .resetn(resetn), .xmit_ready(x_ready));

  task check(input logic [36:0] seen, input logic [36:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task timed_out;
    miscompares++;
    close_out;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge clk_sys);
    if (k == 20)
      timed_out;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task usb_word(input logic [31:0] d, input logic e);
    @(posedge clk_sys);
    w_valid <= 1'b1;
    w_data <= d;
    w_end <= e;
    @(posedge clk_sys);
    for (k = 0; k < 50 && w_ready !== 1'b1; k++)
      @(posedge clk_sys);
    if (k == 50)
      timed_out;
    w_valid <= 1'b0;
    w_end <= 1'b0;
  endtask

  // A byte lane is expected when it lies between the offset and its end.
  task send_buf(input logic f, input logic l, input int o, input int sz,
                input logic [31:0] b);
    int nw, j, m;
    logic [31:0] a, w;
    logic [3:0] be;
    nw = (o + sz + 3) / 4;
    a = 32'h0;
    a[10:0] = sz[10:0];
    a[17:16] = o[1:0];
    a[frame_fifo_pkg::A_FIRST_POS] = f;
    a[frame_fifo_pkg::A_LAST_POS] = l;
    usb_word(a, 1'b0);
    usb_word(b, nw == 0);
    for (j = 0; j < nw; j++)
    begin
      w = $random(seed);
      for (m = 0; m < 4; m++)
        be[m] = (4 * j + m >= o) && (4 * j + m < o + sz);
      notes.push_back({be, l && j == nw - 1, w});
      usb_word(w, j == nw - 1);
    end
  endtask

  task drain;
    for (k = 0; k < 300 && notes.size() > 0; k++)
      @(posedge clk_sys);
    if (k == 300)
      timed_out;
    repeat (4) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys)
  begin
    if (stop_p === 1'b1)
      stops++;
    if (x_valid === 1'b1 && x_ready === 1'b1)
    begin
      if (notes.size() == 0)
        check(37'h1, 37'h0);
      else
        check({x_be, x_last, x_data}, notes.pop_front());
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    check({w_ready, rx_enable}, 37'h2);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check({rdata[0], rx_enable}, 37'h3);
    apb(1'b0, 12'h0f0, 32'h0);
    check({rerr, rdata}, 37'h1_0000_0000);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check({stops, rdata[1], rx_enable}, 37'h6);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      push <= 1'b1;
      pop <= (i == 3);
      @(posedge clk_sys);
      push <= 1'b0;
      pop <= 1'b0;
    end
    @(posedge clk_sys);
    check({wr_i, rd_i}, {10'h4, 10'h1});
    apb(1'b1, 12'h004, 32'h1);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 12'h004, 32'h0);
    check({rdata[0], wr_i, rd_i}, 37'h0);
    apb(1'b1, 12'h000, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      rx_busy <= 1'b1;
      rx_er <= crc_tab[i][3];
      @(posedge clk_sys);
      {rx_busy, rx_er, done} <= 3'h1;
      {fcs, runt, late, wd} <= {crc_tab[i][4], crc_tab[i][2:0]};
      @(posedge clk_sys);
      done <= 1'b0;
      for (k = 0; k < 10 && strobe !== 1'b1; k++)
        @(posedge clk_sys);
      if (k == 10)
        timed_out;
      check(crc_ok, i < 3);
      if (i < 3)
        check(crc_err, i < 2);
    end
    usb_word(32'h2004, 1'b0);
    usb_word(32'h4, 1'b0);
    usb_word(32'hdead, 1'b0);
    @(posedge clk_sys);
    rewind <= 1'b1;
    @(posedge clk_sys);
    rewind <= 1'b0;
    send_buf(1'b1, 1'b0, 2, 5, 32'h9);
    // Only the checksum bit, bit 14, differs in the second command B.
    send_buf(1'b0, 1'b1, 0, 4, 32'h4009);
    drain;
    check(tx_err, 1'b0);
    send_buf(1'b1, 1'b1, 0, 4, 32'h5);
    drain;
    apb(1'b0, 12'h008, 32'h0);
    check({tx_err, rdata[0]}, 37'h3);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check({tx_err, rdata[0]}, 37'h0);
    send_buf(1'b1, 1'b0, 0, 4, 32'h8);
    send_buf(1'b0, 1'b0, 0, 4, 32'h8);
    send_buf(1'b0, 1'b1, 0, 0, 32'h1008);
    drain;
    check(tx_err, 1'b1);
    // Uncommitted words fill the store until ready drops; rewind frees it.
    for (i = 0; i < 2048; i++)
      usb_word(32'(i), 1'b0);
    @(posedge clk_sys);
    check(w_ready, 1'b0);
    rewind <= 1'b1;
    @(posedge clk_sys);
    rewind <= 1'b0;
    @(posedge clk_sys);
    check(w_ready, 1'b1);
    close_out;
  end
endmodule

`default_nettype wire
